// ### rtl/lfm_fault_monitor.sv
// Fault qualification and gate drive control of the LED driver
`timescale 1ns/1ps
module lfm_fault_monitor
  import lfm_pkg::*;
#(
  parameter int unsigned OPEN_CYC = LFM_OPEN_CYCLES,
  parameter int unsigned SHORT_CYC = LFM_SHORT_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Dimming and comparator inputs
  input wire logic dimming_input,
  input wire lfm_sense_t sense,
  // Gate drive
  output logic gate_drive_out,
  // Open-drain fault pin, low while enabled
  output logic fault_n_out,
  output logic fault_n_oe,
  // Converter shutdown and restart request
  output logic shutdown_q,
  output logic restart_q
);

  localparam int OW = $clog2(OPEN_CYC + 1);
  localparam int SW = $clog2(SHORT_CYC + 1);
  localparam logic [OW-1:0] OPEN_LAST = OW'(OPEN_CYC - 1);
  localparam logic [SW-1:0] SHORT_LAST = SW'(SHORT_CYC - 1);

  lfm_state_t state_q;
  logic [OW-1:0] open_cnt_q;
  logic [SW-1:0] short_cnt_q;
  logic open_flt_q;
  logic short_flt_q;
  logic run_on;
  logic run_q;

  // Converter is enabled for this cycle
  assign run_on = (state_q == LFM_ST_RUN) && dimming_input;

  // Converter was enabled in the previous cycle as well
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      run_q <= LFM_RUN_RST;
    end else begin
      run_q <= run_on;
    end
  end

  // Over-temperature shutdown and automatic restart
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= LFM_ST_RUN;
    end else begin
      unique case (state_q)
        LFM_ST_RUN: begin
          if (sense.overtemp_hot) begin
            state_q <= LFM_ST_SHUT;
          end
        end
        LFM_ST_SHUT: begin
          if (sense.overtemp_cool && !sense.overtemp_hot) begin
            state_q <= LFM_ST_START;
          end
        end
        LFM_ST_START: begin
          state_q <= LFM_ST_RUN;
        end
        default: begin
          state_q <= LFM_ST_SHUT;
        end
      endcase
    end
  end

  // Hysteretic gate drive; it keeps switching under a shorted string
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gate_drive_out <= LFM_DRIVE_RST;
    end else if (!run_on) begin
      gate_drive_out <= 1'b0;
    end else if (sense.sense_above_upper) begin
      gate_drive_out <= 1'b0;
    end else if (sense.sense_below_lower) begin
      gate_drive_out <= 1'b1;
    end
    // An open string never reaches the upper threshold, so drive holds high
  end

  // Open-string accumulation; a low gate drive after the first cycle of on-time ends it
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      open_cnt_q <= '0;
      open_flt_q <= LFM_FLAG_RST;
    end else if (run_on) begin
      if (!gate_drive_out) begin
        // The forced-low drive left by an off-period is no switching cycle
        if (run_q) begin
          open_cnt_q <= '0;
          open_flt_q <= 1'b0;
        end
      end else if (open_cnt_q == OPEN_LAST) begin
        open_flt_q <= 1'b1;
      end else begin
        open_cnt_q <= open_cnt_q + 1'b1;
      end
    end
    // Count held while dimming keeps the converter off
    // Needs a switching cycle in each on-period to clear
  end

  // Continuous short qualification
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      short_cnt_q <= '0;
      short_flt_q <= LFM_FLAG_RST;
    end else if (!sense.short_diff_low) begin
      short_cnt_q <= '0;
      short_flt_q <= 1'b0;
    end else if (short_cnt_q == SHORT_LAST) begin
      short_flt_q <= 1'b1;
    end else begin
      short_cnt_q <= short_cnt_q + 1'b1;
    end
  end

  // Fault pin and shutdown outputs
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fault_n_oe <= LFM_FAULT_OE_RST;
      fault_n_out <= LFM_FAULT_LEVEL;
      shutdown_q <= LFM_SHUTDOWN_RST;
      restart_q <= LFM_RESTART_RST;
    end else begin
      fault_n_oe <= open_flt_q || short_flt_q ||
                    (state_q != LFM_ST_RUN);
      fault_n_out <= LFM_FAULT_LEVEL;
      shutdown_q <= (state_q == LFM_ST_SHUT);
      restart_q <= (state_q == LFM_ST_START);
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);

  sequence s_shut_entered;
    state_q == LFM_ST_SHUT;
  endsequence

  sequence s_shut_visible;
    !gate_drive_out && fault_n_oe && shutdown_q;
  endsequence

  sequence s_restart;
    state_q == LFM_ST_START ##1 state_q == LFM_ST_RUN && restart_q;
  endsequence

  a_open_flag_set: assert property (
    run_on && gate_drive_out && open_cnt_q == OPEN_LAST |=> open_flt_q
  ) else $error("open fault not flagged at full count");

  a_drive_held_open: assert property (
    run_on && gate_drive_out && !sense.sense_above_upper |=> gate_drive_out
  ) else $error("gate drive dropped without upper threshold");

  a_fault_release: assert property (
    !open_flt_q && !short_flt_q && state_q == LFM_ST_RUN |=> !fault_n_oe
  ) else $error("fault not released after condition cleared");

  a_short_flag_set: assert property (
    sense.short_diff_low && short_cnt_q == SHORT_LAST |=> short_flt_q
  ) else $error("short fault not flagged at full count");

  a_short_keeps_switch: assert property (
    short_flt_q && run_on && sense.sense_below_lower &&
    !sense.sense_above_upper |=> gate_drive_out && !shutdown_q
  ) else $error("switching stopped under short fault");

  a_otp_shutdown: assert property (
    state_q == LFM_ST_RUN && sense.overtemp_hot |=>
      s_shut_entered ##1 s_shut_visible
  ) else $error("over-temperature did not shut down");

  a_otp_restart: assert property (
    state_q == LFM_ST_SHUT && sense.overtemp_cool && !sense.overtemp_hot
    |=> s_restart
  ) else $error("no restart after cooling");

  a_dimmed_hold: assert property (
    !dimming_input |=> open_cnt_q == $past(open_cnt_q) &&
                       open_flt_q == $past(open_flt_q)
  ) else $error("open timer changed while dimmed off");

  a_open_keep_count: assert property (
    run_on && !run_q && !gate_drive_out |=>
      open_cnt_q == $past(open_cnt_q) && open_flt_q == $past(open_flt_q)
  ) else $error("open timer cleared by forced-low drive");

  a_shut_drive_off: assert property (
    state_q != LFM_ST_RUN |=> !gate_drive_out
  ) else $error("gate drive active while not running");

  a_fault_any: assert property (
    (open_flt_q || short_flt_q) |=> fault_n_oe && !fault_n_out
  ) else $error("fault pin not pulled low");

  a_short_restart: assert property (
    !sense.short_diff_low |=> short_cnt_q == '0 && !short_flt_q
  ) else $error("short timer not restarted");

endmodule : lfm_fault_monitor

// ### rtl/lfm_pkg.sv
// Shared constants and types of the LED fault monitor
package lfm_pkg;

  // Clock period of clk_sys in picoseconds (40 MHz)
  localparam int unsigned LFM_CLK_PERIOD_PS = 25000;

  // Qualification times as specified
  localparam int unsigned LFM_OPEN_TIME_US = 416;
  localparam int unsigned LFM_SHORT_TIME_MS = 23;

  // Least times round up to whole clock cycles
  localparam int unsigned LFM_OPEN_CYCLES =
    (LFM_OPEN_TIME_US * 1000000 + LFM_CLK_PERIOD_PS - 1) / LFM_CLK_PERIOD_PS;
  localparam longint unsigned LFM_SHORT_PS =
    64'(LFM_SHORT_TIME_MS) * 64'd1000000000;
  localparam int unsigned LFM_SHORT_CYCLES =
    32'((LFM_SHORT_PS + LFM_CLK_PERIOD_PS - 1) / LFM_CLK_PERIOD_PS);

  // Values after reset
  localparam logic LFM_DRIVE_RST = 1'b0;
  localparam logic LFM_FAULT_OE_RST = 1'b0;
  localparam logic LFM_SHUTDOWN_RST = 1'b0;
  localparam logic LFM_FLAG_RST = 1'b0;
  localparam logic LFM_RUN_RST = 1'b0;
  localparam logic LFM_RESTART_RST = 1'b0;

  // Level shown on the open-drain fault pin while it is enabled
  localparam logic LFM_FAULT_LEVEL = 1'b0;

  // Converter state, one-hot
  typedef enum logic [2:0] {
    LFM_ST_RUN   = 3'h1,
    LFM_ST_SHUT  = 3'h2,
    LFM_ST_START = 3'h4
  } lfm_state_t;

  // Comparator results from the analog front end
  typedef struct packed {
    logic sense_above_upper; // Sense ramp reached upper threshold
    logic sense_below_lower; // Sense ramp fell to lower threshold
    logic short_diff_low;    // current_sense_node - short_sense_input < 1V
    logic overtemp_hot;      // Junction above the shutdown point
    logic overtemp_cool;     // Junction cooled by the hysteresis step
  } lfm_sense_t;

endpackage : lfm_pkg

// ### test/lfm_string_model.sv
// Behavioural LED string and sense front end for the fault monitor
`timescale 1ns/1ps
module lfm_string_model
  import lfm_pkg::*;
(
  // Drive from the controller
  input wire logic gate_drive_out,
  // Conditions imposed by the bench
  input wire logic open_str,
  input wire logic short_str,
  input wire logic hot,
  input wire logic cool,
  // Comparator results
  output lfm_sense_t sense
);
  // Open string leaves no sense current, so the ramp never rises
  assign sense.sense_above_upper = gate_drive_out & ~open_str;
  assign sense.sense_below_lower = ~gate_drive_out | open_str;
  assign sense.short_diff_low = short_str;
  assign sense.overtemp_hot = hot;
  assign sense.overtemp_cool = cool;
endmodule : lfm_string_model

// ### test/tb.sv
// Self-checking bench of the LED fault monitor
`timescale 1ns/1ps
module tb;
  import lfm_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic dimming_input = 1'b0;
  logic open_str = 1'b0;
  logic short_str = 1'b0;
  logic hot = 1'b0;
  logic cool = 1'b0;
  lfm_sense_t sense;
  logic drive, f_out, f_oe, shut, restart, fault_pin;
  int err_total = 0;
  int cmp_count = 0;
  // Pin has a pull-up when not driven
  assign fault_pin = f_oe ? f_out : 1'b1;
  always #12.5 clk_sys = ~clk_sys;
  lfm_fault_monitor #(.OPEN_CYC(20), .SHORT_CYC(30)) u_lfm_fault_monitor (
    .clk_sys(clk_sys), .reset_n(reset_n),
    .dimming_input(dimming_input),
    .sense(sense), .gate_drive_out(drive), .fault_n_out(f_out),
    .fault_n_oe(f_oe), .shutdown_q(shut), .restart_q(restart));
  lfm_string_model u_lfm_string_model (
    .gate_drive_out(drive), .open_str(open_str), .short_str(short_str),
    .hot(hot), .cool(cool), .sense(sense));
  task close_out;
    $display("tb: %0d compares, %0d errors", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : close_out
  task chk(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : cyc
  task test_open;
    open_str = 1'b1;
    cyc(12);
    chk("drive", 1'b1, drive);
    chk("fault", 1'b1, fault_pin);
    dimming_input = 1'b0; // Off-period held 20 clock cycles
    cyc(20);
    chk("fault", 1'b1, fault_pin);
    dimming_input = 1'b1;
    cyc(16);
    chk("fault", 1'b0, fault_pin);
    open_str = 1'b0;
    cyc(6);
    chk("fault", 1'b1, fault_pin);
    $display("test_open done");
  endtask : test_open
  task test_short;
    logic d0;
    short_str = 1'b1;
    cyc(25);
    chk("fault", 1'b1, fault_pin);
    short_str = 1'b0;
    cyc(1);
    short_str = 1'b1;
    cyc(25);
    chk("fault", 1'b1, fault_pin);
    cyc(10);
    chk("fault", 1'b0, fault_pin);
    d0 = drive;
    cyc(1);
    chk("switching", ~d0, drive);
    short_str = 1'b0;
    cyc(4);
    chk("fault", 1'b1, fault_pin);
    $display("test_short done");
  endtask : test_short
  task test_temp;
    hot = 1'b1;
    cyc(3);
    chk("shutdown", 1'b1, shut);
    chk("drive", 1'b0, drive);
    chk("fault", 1'b0, fault_pin);
    hot = 1'b0;
    cool = 1'b1;
    for (int i = 0; i < 8 && restart !== 1'b1; i++) cyc(1);
    chk("restart", 1'b1, restart);
    cool = 1'b0;
    cyc(3);
    chk("shutdown", 1'b0, shut);
    chk("fault", 1'b1, fault_pin);
    $display("test_temp done");
  endtask : test_temp
  task test_reset;
    open_str = 1'b1;
    cyc(12);
    reset_n = 1'b0;
    cyc(2);
    chk("fault", 1'b1, fault_pin);
    chk("drive", 1'b0, drive);
    reset_n = 1'b1;
    cyc(14);
    chk("fault", 1'b1, fault_pin);
    cyc(10);
    chk("fault", 1'b0, fault_pin);
    open_str = 1'b0;
    cyc(6);
    chk("fault", 1'b1, fault_pin);
    $display("test_reset done");
  endtask : test_reset
  initial begin
    repeat (12) @(posedge clk_sys);
    #2;
    reset_n = 1'b1;
    chk("fault", 1'b1, fault_pin);
    chk("drive", 1'b0, drive);
    dimming_input = 1'b1;
    test_open();
    test_short();
    test_temp();
    test_reset();
    close_out();
  end
  initial begin
    #50000;
    err_total++;
    close_out();
  end
endmodule : tb
